// File: rtl/psd_pkg.sv
package psd_pkg;

  // Register byte offsets
  localparam logic [7:0] PSD_OFS_TABLE_PAGE   = 8'h00;
  localparam logic [7:0] PSD_OFS_VIS_PAGE     = 8'h04;
  localparam logic [7:0] PSD_OFS_CORE_CONTROL = 8'h08;
  localparam logic [7:0] PSD_OFS_STATUS       = 8'h0C;
  localparam logic [7:0] PSD_OFS_LAST_ADDR    = 8'h10;

  // Field positions
  localparam int PSD_VIS_EN_BIT  = 2;
  localparam int PSD_CFG_SEL_BIT = 7;
  localparam int PSD_EA_WIN_BIT  = 15;
  localparam int PSD_ST_BUSY_BIT = 0;
  localparam int PSD_ST_REDIR_BIT = 1;
  localparam int PSD_ST_CFG_BIT  = 2;
  localparam int PSD_ST_REFUSED_BIT = 3;

  // Reset values
  localparam logic [7:0] PSD_RST_TABLE_PAGE = 8'h00;
  localparam logic [7:0] PSD_RST_VIS_PAGE   = 8'h00;
  localparam logic       PSD_RST_VIS_EN     = 1'b0;

  // Added cycles for window reads
  localparam logic [1:0] PSD_PAD_MOVE     = 2'h1;
  localparam logic [1:0] PSD_PAD_OTHER    = 2'h2;
  localparam logic [1:0] PSD_PAD_RPT_EDGE = 2'h2;
  localparam logic [1:0] PSD_PAD_RPT_MID  = 2'h0;

  // AXI responses
  localparam logic [1:0] PSD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PSD_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PSD_OP_DATA_RD = 3'h0,
    PSD_OP_DATA_WR = 3'h1,
    PSD_OP_TRD_LO  = 3'h2,
    PSD_OP_TRD_HI  = 3'h3,
    PSD_OP_TWR_LO  = 3'h4,
    PSD_OP_TWR_HI  = 3'h5
  } psd_op_e;

  typedef enum logic [1:0] {
    PSD_CLS_MOVE  = 2'h0,
    PSD_CLS_DMOVE = 2'h1,
    PSD_CLS_OTHER = 2'h2
  } psd_cls_e;

  typedef struct packed {
    logic        valid;
    psd_op_e     op;
    logic        byte_mode;
    logic [15:0] effective_address;
    logic [15:0] wdata;
    psd_cls_e    cls;
    logic        in_repeat;
    logic        rpt_first;
    logic        rpt_last;
    logic        rpt_irq_exit;
    logic        rpt_reentry;
  } psd_cpu_req_s;

  typedef struct packed {
    logic        done;
    logic        redirected;
    logic        refused;
    logic [15:0] data;
  } psd_cpu_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0]  wmask;
  } psd_mem_req_s;

endpackage

// File: rtl/psd_program_space_access.sv
`timescale 1ns/100ps
module psd_program_space_access
  import psd_pkg::*;
(
  input  logic         clk_in,
  input  logic         rst_in,
  input  logic [7:0]   s_axi_awaddr_in,
  input  logic         s_axi_awvalid_in,
  output logic         s_axi_awready_out,
  input  logic [31:0]  s_axi_wdata_in,
  input  logic [3:0]   s_axi_wstrb_in,
  input  logic         s_axi_wvalid_in,
  output logic         s_axi_wready_out,
  output logic [1:0]   s_axi_bresp_out,
  output logic         s_axi_bvalid_out,
  input  logic         s_axi_bready_in,
  input  logic [7:0]   s_axi_araddr_in,
  input  logic         s_axi_arvalid_in,
  output logic         s_axi_arready_out,
  output logic [31:0]  s_axi_rdata_out,
  output logic [1:0]   s_axi_rresp_out,
  output logic         s_axi_rvalid_out,
  input  logic         s_axi_rready_in,
  input  psd_cpu_req_s cpu_req_in,
  output logic         cpu_busy_out,
  output psd_cpu_rsp_s cpu_rsp_out,
  output psd_mem_req_s mem_req_out,
  input  logic         mem_ack_in,
  input  logic [23:0]  mem_rdata_in
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_PAD   = 3'b100
  } psd_state_e;

  psd_state_e   state_r;
  logic [7:0]   table_page_r;
  logic [7:0]   visibility_page_r;
  logic         visibility_enable_r;
  logic         refused_r;
  logic [23:0]  last_addr_r;
  psd_op_e      op_r;
  logic         byte_mode_r;
  logic         byte_sel_r;
  logic [1:0]   pad_r;
  logic [15:0]  result_r;
  logic         aw_held_r;
  logic         w_held_r;
  logic [7:0]   aw_addr_r;
  logic [31:0]  w_data_r;
  logic [3:0]   w_strb_r;
  logic         wr_fire;
  logic [7:0]   wr_addr;
  logic [31:0]  wr_data;
  logic [3:0]   wr_strb;
  logic         wr_hit;
  logic         rd_hit;
  logic [31:0]  rd_data;
  logic         win_hit;
  logic         tbl_op;
  logic [23:0]  prog_addr;
  logic [1:0]   pad_nxt;
  logic [15:0]  steer_nxt;
  logic         start;
  logic         needs_mem;

  // Register write path: address and data taken in either order
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_in;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata_in;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb_in;
  assign wr_fire = (aw_held_r || (s_axi_awvalid_in && s_axi_awready_out)) &&
                   (w_held_r || (s_axi_wvalid_in && s_axi_wready_out)) &&
                   !s_axi_bvalid_out;
  assign wr_hit  = (wr_addr == PSD_OFS_TABLE_PAGE) || (wr_addr == PSD_OFS_VIS_PAGE) ||
                   (wr_addr == PSD_OFS_CORE_CONTROL);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_r         <= 1'b0;
      w_held_r          <= 1'b0;
      aw_addr_r         <= 8'h00;
      w_data_r          <= 32'h0000_0000;
      w_strb_r          <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= PSD_RESP_OKAY;
    end else begin
      s_axi_awready_out <= !aw_held_r && !s_axi_bvalid_out && !wr_fire &&
                           !(s_axi_awvalid_in && s_axi_awready_out);
      s_axi_wready_out  <= !w_held_r && !s_axi_bvalid_out && !wr_fire &&
                           !(s_axi_wvalid_in && s_axi_wready_out);
      if (wr_fire) begin
        aw_held_r        <= 1'b0;
        w_held_r         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? PSD_RESP_OKAY : PSD_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata_in;
          w_strb_r <= s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
          s_axi_bvalid_out <= 1'b0;
        end
      end
    end
  end

  // Page and control registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      table_page_r        <= PSD_RST_TABLE_PAGE;
      visibility_page_r   <= PSD_RST_VIS_PAGE;
      visibility_enable_r <= PSD_RST_VIS_EN;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_addr == PSD_OFS_TABLE_PAGE) begin
        table_page_r <= wr_data[7:0];
      end
      if (wr_addr == PSD_OFS_VIS_PAGE) begin
        visibility_page_r <= wr_data[7:0];
      end
      if (wr_addr == PSD_OFS_CORE_CONTROL) begin
        visibility_enable_r <= wr_data[PSD_VIS_EN_BIT];
      end
    end
  end

  // Register read path
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (s_axi_araddr_in)
      PSD_OFS_TABLE_PAGE:   rd_data[7:0] = table_page_r;
      PSD_OFS_VIS_PAGE:     rd_data[7:0] = visibility_page_r;
      PSD_OFS_CORE_CONTROL: rd_data[PSD_VIS_EN_BIT] = visibility_enable_r;
      PSD_OFS_STATUS: begin
        rd_data[PSD_ST_BUSY_BIT]    = (state_r != ST_IDLE);
        rd_data[PSD_ST_REDIR_BIT]   = cpu_rsp_out.redirected;
        rd_data[PSD_ST_CFG_BIT]     = last_addr_r[23];
        rd_data[PSD_ST_REFUSED_BIT] = refused_r;
      end
      PSD_OFS_LAST_ADDR:    rd_data[23:0] = last_addr_r;
      default:              rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= PSD_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_data;
        s_axi_rresp_out  <= rd_hit ? PSD_RESP_OKAY : PSD_RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Address generation
  assign tbl_op  = (cpu_req_in.op != PSD_OP_DATA_RD) && (cpu_req_in.op != PSD_OP_DATA_WR);
  assign win_hit = !tbl_op && cpu_req_in.effective_address[PSD_EA_WIN_BIT] &&
                   visibility_enable_r;
  assign start   = cpu_req_in.valid && (state_r == ST_IDLE);
  // Table accesses and window reads go to program memory
  assign needs_mem = tbl_op || (win_hit && cpu_req_in.op == PSD_OP_DATA_RD);

  always_comb begin
    if (tbl_op) begin
      prog_addr = {table_page_r, cpu_req_in.effective_address};
    end else begin
      prog_addr = {1'b0, visibility_page_r,
                   cpu_req_in.effective_address[14:0]};
    end
  end

  // Added cycles for a window read
  always_comb begin
    if (!cpu_req_in.in_repeat) begin
      pad_nxt = (cpu_req_in.cls == PSD_CLS_OTHER) ? PSD_PAD_OTHER : PSD_PAD_MOVE;
    end else if (cpu_req_in.rpt_first || cpu_req_in.rpt_last ||
                 cpu_req_in.rpt_irq_exit || cpu_req_in.rpt_reentry) begin
      pad_nxt = PSD_PAD_RPT_EDGE;
    end else begin
      pad_nxt = PSD_PAD_RPT_MID;
    end
  end

  // Read data steering
  always_comb begin
    steer_nxt = 16'h0000;
    case (op_r)
      PSD_OP_DATA_RD: steer_nxt = mem_rdata_in[15:0];
      PSD_OP_TRD_LO: begin
        if (!byte_mode_r) begin
          steer_nxt = mem_rdata_in[15:0];
        end else begin
          steer_nxt[7:0] = byte_sel_r ? mem_rdata_in[15:8] : mem_rdata_in[7:0];
        end
      end
      PSD_OP_TRD_HI: begin
        if (!byte_mode_r || !byte_sel_r) begin
          steer_nxt[7:0] = mem_rdata_in[23:16];
        end
      end
      default: steer_nxt = 16'h0000;
    endcase
  end

  // Access sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r     <= ST_IDLE;
      op_r        <= PSD_OP_DATA_RD;
      byte_mode_r <= 1'b0;
      byte_sel_r  <= 1'b0;
      pad_r       <= 2'h0;
      result_r    <= 16'h0000;
      refused_r   <= 1'b0;
      last_addr_r <= 24'h00_0000;
      mem_req_out <= '0;
      cpu_rsp_out <= '0;
    end else begin
      cpu_rsp_out.done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            op_r        <= cpu_req_in.op;
            byte_mode_r <= cpu_req_in.byte_mode;
            byte_sel_r  <= cpu_req_in.effective_address[0];
            pad_r       <= pad_nxt;
            if (needs_mem) begin
              state_r           <= ST_FETCH;
              last_addr_r       <= prog_addr;
              mem_req_out.valid <= 1'b1;
              mem_req_out.addr  <= prog_addr;
              mem_req_out.we    <= (cpu_req_in.op == PSD_OP_TWR_LO) ||
                                   (cpu_req_in.op == PSD_OP_TWR_HI);
              mem_req_out.wdata <= 24'h00_0000;
              mem_req_out.wmask <= 3'h0;
              if (cpu_req_in.op == PSD_OP_TWR_LO) begin
                mem_req_out.wdata <= {8'h00, cpu_req_in.byte_mode ?
                                     {2{cpu_req_in.wdata[7:0]}} : cpu_req_in.wdata};
                mem_req_out.wmask <= !cpu_req_in.byte_mode ? 3'h3 :
                                     (cpu_req_in.effective_address[0] ? 3'h2 : 3'h1);
              end
              if (cpu_req_in.op == PSD_OP_TWR_HI) begin
                mem_req_out.wdata <= {cpu_req_in.wdata[7:0], 16'h0000};
                mem_req_out.wmask <= (cpu_req_in.byte_mode &&
                                      cpu_req_in.effective_address[0]) ? 3'h0 : 3'h4;
              end
            end else begin
              cpu_rsp_out.done       <= 1'b1;
              cpu_rsp_out.redirected <= win_hit;
              cpu_rsp_out.refused    <= win_hit;
              cpu_rsp_out.data       <= 16'h0000;
              refused_r              <= win_hit;
            end
          end
        end
        ST_FETCH: begin
          if (mem_ack_in) begin
            mem_req_out.valid <= 1'b0;
            refused_r         <= 1'b0;
            if (op_r == PSD_OP_DATA_RD && pad_r != 2'h0) begin
              state_r  <= ST_PAD;
              result_r <= steer_nxt;
            end else begin
              state_r                <= ST_IDLE;
              cpu_rsp_out.done       <= 1'b1;
              cpu_rsp_out.redirected <= (op_r == PSD_OP_DATA_RD);
              cpu_rsp_out.refused    <= 1'b0;
              cpu_rsp_out.data       <= steer_nxt;
            end
          end
        end
        ST_PAD: begin
          pad_r <= pad_r - 2'h1;
          if (pad_r == 2'h1) begin
            state_r                <= ST_IDLE;
            cpu_rsp_out.done       <= 1'b1;
            cpu_rsp_out.redirected <= 1'b1;
            cpu_rsp_out.refused    <= 1'b0;
            cpu_rsp_out.data       <= result_r;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Busy flag stalls the requester from the cycle after a table access or window read is taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_busy_out <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE:  cpu_busy_out <= start && (tbl_op ||
                                  (win_hit && cpu_req_in.op == PSD_OP_DATA_RD));
        ST_FETCH: cpu_busy_out <= !(mem_ack_in && !(op_r == PSD_OP_DATA_RD && pad_r != 2'h0));
        ST_PAD:   cpu_busy_out <= (pad_r != 2'h1);
        default:  cpu_busy_out <= 1'b0;
      endcase
    end
  end

endmodule // psd_program_space_access

// File: tb/psd_mem_model.sv
`timescale 1ns/100ps
module psd_mem_model
  import psd_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire psd_mem_req_s req_in,
  input  wire logic         slow_in,
  output logic              ack_out,
  output logic [23:0]       rdata_out
);
  logic [1:0] cnt_r;
  // Answers at once or after two waits; the data line changes every cycle outside a transfer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r     <= 2'h0;
      ack_out   <= 1'b0;
      rdata_out <= 24'h000000;
    end else if (req_in.valid && !ack_out && cnt_r >= {slow_in, 1'b0}) begin
      ack_out   <= 1'b1;
      // User words keep their upper byte all ones or all zeros
      rdata_out <= {req_in.addr[23] ? req_in.addr[7:0] ^ req_in.addr[23:16] :
                    {8{req_in.addr[1]}}, req_in.addr[15:0] ^ 16'h3C96};
    end else begin
      ack_out   <= 1'b0;
      cnt_r     <= (req_in.valid && !ack_out) ? cnt_r + 2'h1 : 2'h0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule // psd_mem_model

// File: tb/psd_program_space_access_sva.sv
`timescale 1ns/100ps
module psd_program_space_access_sva
  import psd_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         rst_in,
  input wire psd_cpu_req_s cpu_req_in,
  input wire logic         cpu_busy_out,
  input wire psd_cpu_rsp_s cpu_rsp_out,
  input wire psd_mem_req_s mem_req_out,
  input wire logic         mem_ack_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  psd_op_e    op_r;
  logic [1:0] pad_r;
  logic       take;
  logic       ackd;
  assign take = cpu_req_in.valid && !cpu_busy_out && !mem_req_out.valid;
  assign ackd = mem_req_out.valid && mem_ack_in;
  // Remembers the accepted operation and the padding it earns
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_r  <= PSD_OP_DATA_RD;
      pad_r <= 2'h0;
    end else if (take) begin
      op_r  <= cpu_req_in.op;
      pad_r <= !cpu_req_in.in_repeat ? (cpu_req_in.cls == PSD_CLS_OTHER ? 2'h2 : 2'h1) :
               ((cpu_req_in.rpt_first || cpu_req_in.rpt_last || cpu_req_in.rpt_irq_exit ||
                 cpu_req_in.rpt_reentry) ? 2'h2 : 2'h0);
    end
  end
  a_win_addr_form: assert property ($rose(mem_req_out.valid) && op_r == PSD_OP_DATA_RD |->
    !mem_req_out.we && !mem_req_out.addr[23] &&
    mem_req_out.addr[14:0] == $past(cpu_req_in.effective_address[14:0])) else $error("bad window");
  a_win_needs_hi: assert property ($rose(mem_req_out.valid) && op_r == PSD_OP_DATA_RD |->
    $past(cpu_req_in.effective_address[15])) else $error("window below 0x8000");
  a_tbl_addr_form: assert property ($rose(mem_req_out.valid) && op_r >= PSD_OP_TRD_LO |->
    mem_req_out.addr[15:0] == $past(cpu_req_in.effective_address) &&
    mem_req_out.we == (op_r >= PSD_OP_TWR_LO)) else $error("bad table access");
  a_mem_req_hold: assert property (mem_req_out.valid && !mem_ack_in |=>
    mem_req_out.valid && $stable(mem_req_out.addr)) else $error("request dropped");
  a_tbl_done_next: assert property (ackd && op_r >= PSD_OP_TRD_LO |=>
    cpu_rsp_out.done && !cpu_busy_out) else $error("table done late");
  a_pad_one_cycle: assert property (ackd && op_r == PSD_OP_DATA_RD && pad_r == 2'h1 |=>
    !cpu_rsp_out.done ##1 cpu_rsp_out.done) else $error("one pad wrong");
  a_pad_two_cycles: assert property (ackd && op_r == PSD_OP_DATA_RD && pad_r == 2'h2 |=>
    !cpu_rsp_out.done [*2] ##1 cpu_rsp_out.done) else $error("two pads wrong");
  a_pad_none_mid: assert property (ackd && op_r == PSD_OP_DATA_RD && pad_r == 2'h0 |=>
    cpu_rsp_out.done) else $error("mid repeat padded");
  a_hi_phantom_zero: assert property (cpu_rsp_out.done && op_r == PSD_OP_TRD_HI |->
    cpu_rsp_out.data[15:8] == 8'h00) else $error("phantom byte set");
  a_wr_no_fetch: assert property (take && cpu_req_in.op == PSD_OP_DATA_WR |=>
    !mem_req_out.valid && cpu_rsp_out.done) else $error("data write fetched");
  c_pad_two: cover property (ackd && op_r == PSD_OP_DATA_RD && pad_r == 2'h2);
  c_refused: cover property (cpu_rsp_out.done && cpu_rsp_out.refused);
  c_high_write: cover property (ackd && op_r == PSD_OP_TWR_HI);
  c_pad_none: cover property (ackd && op_r == PSD_OP_DATA_RD && pad_r == 2'h0);
endmodule // psd_program_space_access_sva

bind psd_program_space_access psd_program_space_access_sva i_psd_program_space_access_sva (
  .clk_in(clk_in), .rst_in(rst_in), .cpu_req_in(cpu_req_in), .cpu_busy_out(cpu_busy_out),
  .cpu_rsp_out(cpu_rsp_out), .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in));

// File: tb/test_program_space_data_access.sv
`timescale 1ns/100ps
module test_program_space_data_access
  import psd_pkg::*;
();
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic [7:0]        awaddr = 8'h00;
  logic [7:0]        araddr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  wire logic         awready, wready, bvalid, arready, rvalid, busy, ack;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  wire logic [23:0]  mrdata;
  psd_cpu_req_s      req = '0;
  wire psd_cpu_rsp_s rsp;
  wire psd_mem_req_s mreq;
  int                fails = 0, samples_checked = 0, cyc = 0;
  logic [31:0]       seed = 32'h2873DB6E;
  logic [7:0]        tp, vp;
  logic              ven;

  psd_program_space_access i_psd_program_space_access (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .cpu_req_in(req), .cpu_busy_out(busy),
    .cpu_rsp_out(rsp), .mem_req_out(mreq), .mem_ack_in(ack), .mem_rdata_in(mrdata));
  psd_mem_model i_psd_mem_model (.clk_in(clk_in), .rst_in(rst_in), .req_in(mreq),
    .slow_in(slow), .ack_out(ack), .rdata_out(mrdata));

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [23:0] word(input logic [23:0] a);
    return {a[23] ? a[7:0] ^ a[23:16] : {8{a[1]}}, a[15:0] ^ 16'h3C96};
  endfunction
  function automatic logic [23:0] msk(input logic [2:0] k);
    return {{8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
  endfunction
  function automatic logic [15:0] steer(input psd_cpu_req_s q, input logic [23:0] w);
    if (q.op == PSD_OP_TRD_HI) begin
      return (q.byte_mode && q.effective_address[0]) ? 16'h0000 : {8'h00, w[23:16]};
    end
    if (q.byte_mode) begin
      return {8'h00, q.effective_address[0] ? w[15:8] : w[7:0]};
    end
    return w[15:0];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, wd;
    aw = 1'b0;
    wd = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && wd)) begin
      @(posedge clk_in);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_in); while (rvalid !== 1'b1);
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
    rready <= 1'b0;
  endtask
  task automatic cpu_run(input psd_cpu_req_s q);
    logic         win, tbl, mem, saw, wr;
    psd_mem_req_s m;
    logic [23:0]  a;
    logic [2:0]   k;
    win = q.op <= PSD_OP_DATA_WR && q.effective_address[15] && ven;
    tbl = q.op >= PSD_OP_TRD_LO;
    wr = q.op >= PSD_OP_TWR_LO;
    mem = tbl || (win && q.op == PSD_OP_DATA_RD);
    a = tbl ? {tp, q.effective_address} : {1'b0, vp, q.effective_address[14:0]};
    k = q.op == PSD_OP_TWR_HI ? ((q.byte_mode && q.effective_address[0]) ? 3'h0 : 3'h4) :
        (q.byte_mode ? (q.effective_address[0] ? 3'h2 : 3'h1) : 3'h3);
    saw = 1'b0;
    m = '0;
    @(posedge clk_in);
    req <= q;
    slow <= seed[5];
    @(posedge clk_in);
    req.valid <= 1'b0;
    do begin
      @(posedge clk_in);
      if (mreq.valid === 1'b1) begin
        saw = 1'b1;
        m = mreq;
      end
    end while (rsp.done !== 1'b1);
    chk("fetch", mem, saw);
    chk("redirected", win, rsp.redirected);
    chk("refused", win && q.op == PSD_OP_DATA_WR, rsp.refused);
    if (mem) chk("address", a, m.addr);
    if (mem) chk("write", wr, m.we);
    if (wr) chk("mask", k, m.wmask);
    if (wr) chk("wdata", {q.wdata[7:0], q.byte_mode ? {2{q.wdata[7:0]}} : q.wdata} & msk(k),
      m.wdata & msk(k));
    if (q.op <= PSD_OP_TRD_HI && q.op != PSD_OP_DATA_WR)
      chk("data", mem ? steer(q, word(a)) : 16'h0, rsp.data);
    if (mem) axi_rd(PSD_OFS_LAST_ADDR, {8'h00, a}, PSD_RESP_OKAY);
    if (mem) axi_rd(PSD_OFS_STATUS, (32'(a[23]) << PSD_ST_CFG_BIT) |
      (32'(win) << PSD_ST_REDIR_BIT), PSD_RESP_OKAY);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    psd_cpu_req_s q;
    logic [31:0]  r;
    logic [15:0]  ea_c [3] = '{16'h8000, 16'hFFFF, 16'h7FFF};
    psd_op_e      op_c [3] = '{PSD_OP_DATA_RD, PSD_OP_TRD_HI, PSD_OP_DATA_RD};
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    axi_rd(PSD_OFS_TABLE_PAGE, {24'h0, PSD_RST_TABLE_PAGE}, PSD_RESP_OKAY);
    axi_rd(PSD_OFS_VIS_PAGE, {24'h0, PSD_RST_VIS_PAGE}, PSD_RESP_OKAY);
    axi_rd(PSD_OFS_CORE_CONTROL, {29'h0, PSD_RST_VIS_EN, 2'h0}, PSD_RESP_OKAY);
    axi_wr(PSD_OFS_LAST_ADDR, 32'hFFFFFFFF, PSD_RESP_SLVERR);
    axi_rd(8'h14, 32'h0, PSD_RESP_SLVERR);
    wstrb <= 4'h0;
    axi_wr(PSD_OFS_TABLE_PAGE, 32'h0000_00A5, PSD_RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(PSD_OFS_TABLE_PAGE, {24'h0, PSD_RST_TABLE_PAGE}, PSD_RESP_OKAY);
    for (int i = 0; i < 120; i++) begin
      if (i % 8 == 0) begin
        r = rnd();
        tp = (i == 0) ? 8'hFF : r[7:0];
        vp = (i == 0) ? 8'hFF : r[15:8];
        ven = (i == 0) || r[16] || r[17];
        axi_wr(PSD_OFS_TABLE_PAGE, {24'h0, tp}, PSD_RESP_OKAY);
        axi_wr(PSD_OFS_VIS_PAGE, {24'h0, vp}, PSD_RESP_OKAY);
        axi_wr(PSD_OFS_CORE_CONTROL, 32'(ven) << PSD_VIS_EN_BIT, PSD_RESP_OKAY);
      end
      r = rnd();
      q = '0;
      q.valid = 1'b1;
      q.op = (i < 3) ? op_c[i] : psd_op_e'(r[2:0] % 3'h6);
      q.byte_mode = r[3] && q.op >= PSD_OP_TRD_LO;
      q.effective_address = (i < 3) ? ea_c[i] : r[19:4];
      q.wdata = r[31:16];
      q.cls = psd_cls_e'(r[21:20] % 2'h3);
      q.in_repeat = r[22];
      {q.rpt_first, q.rpt_last, q.rpt_irq_exit, q.rpt_reentry} = r[23] ? r[27:24] : 4'h0;
      cpu_run(q);
    end
    stop_test();
  end
endmodule // test_program_space_data_access
